// file: pkg/exc_reply_pkg.sv
// Package: register map, codes and timing constants of the exception reply block
package exc_reply_pkg;
  // AXI4-Lite register byte offsets
  localparam logic [7:0] ctrl_off = 8'h00;
  localparam logic [7:0] timeout_off = 8'h04;
  localparam logic [7:0] delay_off = 8'h08;
  localparam logic [7:0] status_off = 8'h0c;
  localparam logic [7:0] mask_off = 8'h10;
  localparam logic [7:0] fault_off = 8'h14;
  localparam logic [7:0] link_off = 8'h18;
  // Control field positions
  localparam int ctrl_treat_lsb = 0;
  localparam int ctrl_keypad_bit = 4;
  localparam int ctrl_ascii_bit = 5;
  localparam int ctrl_baud_lsb = 8;
  localparam int ctrl_fmt_lsb = 12;
  // Status bit positions
  localparam int st_drop_bit = 0;
  localparam int st_exc_bit = 1;
  localparam int st_timeout_bit = 2;
  // Reset values
  localparam logic [7:0] delay_reset = 8'h01;
  localparam logic [15:0] timeout_reset = 16'h0000;
  localparam logic [31:0] ctrl_reset = 32'h0000_0000;
  localparam logic [7:0] delay_max = 8'hc8;
  // Exception codes
  localparam logic [7:0] exc_func = 8'h01;
  localparam logic [7:0] exc_addr = 8'h02;
  localparam logic [7:0] exc_value = 8'h03;
  localparam logic [7:0] exc_fail = 8'h04;
  localparam logic [7:0] exc_timeout = 8'h0a;
  // Forced keypad link format
  localparam logic [3:0] keypad_baud_code = 4'h5;
  localparam logic [3:0] keypad_fmt_code = 4'h3;
  localparam logic [7:0] func_exc_flag = 8'h80;
  // Timing
  localparam int clk_hz = 20_000_000;
  localparam int delay_unit_us = 2000;
  localparam int delay_unit_cycles = delay_unit_us * (clk_hz / 1_000_000);
  localparam int timeout_unit_ms = 100;
  localparam int timeout_unit_cycles = timeout_unit_ms * (clk_hz / 1000);
endpackage : exc_reply_pkg

// file: pkg/tx_byte_if.sv
// Interface: byte stream from the frame builder to the top
interface tx_byte_if;
  logic valid;
  logic ready;
  logic [7:0] data;
  logic last;
  modport src (output valid, output data, output last, input ready);
  modport dst (input valid, input data, input last, output ready);
endinterface : tx_byte_if

// file: src/exc_frame_builder.sv
// Exception frame builder: RTU and ASCII serialisation with CRC or LRC
module exc_frame_builder
  import exc_reply_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic start,
  input wire logic ascii_mode,
  input wire logic [7:0] slave_addr,
  input wire logic [7:0] func_code,
  input wire logic [7:0] exc_code,
  output logic busy,
  tx_byte_if.src tx
);
  import exc_reply_pkg::*;

  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ 16'ha001) : (r >> 1);
    end
    return r;
  endfunction : crc_step

  function automatic logic [7:0] hex_char(input logic [3:0] n);
    return (n < 4'ha) ? (8'h30 + {4'h0, n}) : (8'h37 + {4'h0, n});
  endfunction : hex_char

  logic [3:0] idx;
  logic [7:0] f_addr, f_func, f_code;
  logic f_ascii;
  wire [7:0] func_mod = f_func | func_exc_flag;
  wire [15:0] crc = crc_step(crc_step(crc_step(16'hffff, f_addr), func_mod), f_code);
  wire [7:0] lrc = 8'(8'h00 - 8'(f_addr + func_mod + f_code));
  wire [3:0] last_idx = f_ascii ? 4'ha : 4'h4;
  logic [7:0] rtu_byte, ascii_byte;

  // RTU: address, function, code, CRC low then high
  always_comb begin
    case (idx)
      4'h0: rtu_byte = f_addr;
      4'h1: rtu_byte = func_mod;
      4'h2: rtu_byte = f_code;
      4'h3: rtu_byte = crc[7:0];
      default: rtu_byte = crc[15:8];
    endcase
  end

  // ASCII: colon, six hex digits, LRC pair, CR LF
  always_comb begin
    case (idx)
      4'h0: ascii_byte = 8'h3a;
      4'h1: ascii_byte = hex_char(f_addr[7:4]);
      4'h2: ascii_byte = hex_char(f_addr[3:0]);
      4'h3: ascii_byte = hex_char(func_mod[7:4]);
      4'h4: ascii_byte = hex_char(func_mod[3:0]);
      4'h5: ascii_byte = hex_char(f_code[7:4]);
      4'h6: ascii_byte = hex_char(f_code[3:0]);
      4'h7: ascii_byte = hex_char(lrc[7:4]);
      4'h8: ascii_byte = hex_char(lrc[3:0]);
      4'h9: ascii_byte = 8'h0d;
      default: ascii_byte = 8'h0a;
    endcase
  end

  assign tx.valid = busy;
  assign tx.data = f_ascii ? ascii_byte : rtu_byte;
  assign tx.last = busy && (idx == last_idx);

  // Latch fields at start, step one byte per accepted beat
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      busy <= 1'b0;
      idx <= 4'h0;
      f_addr <= 8'h00;
      f_func <= 8'h00;
      f_code <= 8'h00;
      f_ascii <= 1'b0;
    end else if (!busy) begin
      if (start) begin
        busy <= 1'b1;
        idx <= 4'h0;
        f_addr <= slave_addr;
        f_func <= func_code; // Top bit forced on output
        f_code <= exc_code;
        f_ascii <= ascii_mode;
      end
    end else if (tx.ready) begin
      busy <= (idx != last_idx);
      idx <= 4'(idx + 4'h1);
    end
  end

  tx_func_a: assert property (@(posedge aclk) disable iff (!aresetn)
      busy && !f_ascii && idx == 4'h1 |-> tx.data[7] == 1'b1)
    else $error("exception function byte lacks top bit");
  // Beats taken in the current frame; the far end may stall, so count handshakes, not cycles
  logic [3:0] beats;
  always_ff @(posedge aclk) begin
    if (!aresetn || !busy) begin
      beats <= 4'h0;
    end else if (tx.ready) begin
      beats <= 4'(beats + 4'h1);
    end
  end

  rtu_len_a: assert property (@(posedge aclk) disable iff (!aresetn)
      busy && !f_ascii && tx.ready && tx.last |-> beats == 4'h4)
    else $error("rtu exception frame not five bytes");
  ascii_head_a: assert property (@(posedge aclk) disable iff (!aresetn)
      busy && f_ascii && idx == 4'h0 |-> tx.data == 8'h3a)
    else $error("ascii frame does not open with colon");
  ascii_tail_a: assert property (@(posedge aclk) disable iff (!aresetn)
      tx.last && f_ascii |-> tx.data == 8'h0a)
    else $error("ascii frame does not end with line feed");
endmodule : exc_frame_builder

// file: src/exc_reply_top.sv
// Top: request verdict, exception reply, display code, idle timeout, reply delay
//
// The implementer's own choices: the register offsets and the AXI4-Lite slave port.
module exc_reply_top
  import exc_reply_pkg::*;
#(
  parameter int delay_unit = delay_unit_cycles,
  parameter int timeout_unit = timeout_unit_cycles
) (
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Request verdict from the frame parser
  input wire logic req_done,
  input wire logic req_comm_err,
  input wire logic [7:0] req_addr,
  input wire logic [7:0] req_func,
  input wire logic req_func_bad,
  input wire logic req_addr_bad,
  input wire logic req_value_bad,
  input wire logic req_exec_fail,
  input wire logic bus_activity,
  // Reply byte stream
  output logic tx_valid,
  output logic [7:0] tx_data,
  output logic tx_last,
  input wire logic tx_ready,
  output logic normal_reply_go,
  // Effective link format and display
  output logic [3:0] eff_baud,
  output logic [3:0] eff_format,
  output logic eff_ascii,
  output logic [7:0] comm_fault_display_code,
  output logic irq
);
  import exc_reply_pkg::*;


  typedef enum logic [1:0] {st_idle = 2'b00, st_wait = 2'b01, st_send = 2'b11} reply_e;
  reply_e state, next_state;

  logic [31:0] ctrl;
  logic [15:0] bus_idle_timeout_period;
  logic [7:0] reply_delay_count;
  logic [7:0] slave_id;
  logic [2:0] status, mask;
  logic [7:0] exc_code_q;
  logic exc_pending;
  logic [31:0] delay_cnt;
  logic [31:0] unit_cnt;
  logic [15:0] idle_units;
  logic timeout_hit;
  logic aw_held, w_held;
  logic [7:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic builder_busy;
  tx_byte_if txi ();

  // Control fields
  wire [1:0] timeout_treatment_setting = ctrl[ctrl_treat_lsb +: 2];
  wire keypad_port_select = ctrl[ctrl_keypad_bit];
  wire [3:0] link_baud_setting = ctrl[ctrl_baud_lsb +: 4];
  wire [3:0] link_format_setting = ctrl[ctrl_fmt_lsb +: 4];
  wire ascii_setting = ctrl[ctrl_ascii_bit];

  // Keypad port overrides baud, format and framing
  assign eff_baud = keypad_port_select ? keypad_baud_code : link_baud_setting;
  assign eff_format = keypad_port_select ? keypad_fmt_code : link_format_setting;
  assign eff_ascii = keypad_port_select ? 1'b0 : ascii_setting;

  // Verdict priority: function, address, value, execution
  wire any_bad = req_func_bad | req_addr_bad | req_value_bad | req_exec_fail;
  wire [7:0] verdict_code = req_func_bad ? exc_func :
                            req_addr_bad ? exc_addr :
                            req_value_bad ? exc_value :
                            exc_fail;
  wire req_ok = req_done && !req_comm_err; // Errored frames vanish here
  wire accept = req_ok && state == st_idle;
  wire delay_done = delay_cnt == 32'h0;

  // Reply sequencing
  always_comb begin
    next_state = state;
    case (state)
      st_idle: if (accept) next_state = st_wait;
      st_wait: if (delay_done) next_state = st_send;
      st_send: if (!exc_pending || (txi.valid && txi.ready && txi.last)) next_state = st_idle;
      default: next_state = st_idle;
    endcase
  end

  wire send_exc = state == st_wait && delay_done && exc_pending;
  assign normal_reply_go = state == st_wait && delay_done && !exc_pending;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= st_idle;
      exc_pending <= 1'b0;
      exc_code_q <= 8'h00;
      delay_cnt <= 32'h0;
    end else begin
      state <= next_state;
      if (accept) begin
        exc_pending <= any_bad;
        exc_code_q <= verdict_code;
        delay_cnt <= 32'(reply_delay_count) * 32'(delay_unit);
      end else if (state == st_wait && !delay_done) begin
        delay_cnt <= delay_cnt - 32'h1;
      end
    end
  end

  exc_frame_builder u_builder (
    .aclk(aclk),
    .aresetn(aresetn),
    .start(send_exc),
    .ascii_mode(eff_ascii),
    .slave_addr(req_addr),
    .func_code(req_func),
    .exc_code(exc_code_q),
    .busy(builder_busy),
    .tx(txi)
  );
  assign tx_valid = txi.valid;
  assign tx_data = txi.data;
  assign tx_last = txi.last;
  assign txi.ready = tx_ready;

  // Idle timeout in 0.1 s units; any traffic restarts it
  wire timeout_armed = bus_idle_timeout_period != 16'h0 && timeout_treatment_setting <= 2'd2;
  assign timeout_hit = timeout_armed && idle_units == bus_idle_timeout_period && !bus_activity;
  always_ff @(posedge aclk) begin
    if (!aresetn || bus_activity || !timeout_armed) begin
      unit_cnt <= 32'h0;
      idle_units <= 16'h0;
    end else if (idle_units != bus_idle_timeout_period) begin
      unit_cnt <= (unit_cnt == 32'(timeout_unit - 1)) ? 32'h0 : unit_cnt + 32'h1;
      if (unit_cnt == 32'(timeout_unit - 1)) idle_units <= idle_units + 16'h1;
    end
  end

  // Display code: decimal digits in two nibbles, latest event wins
  wire [7:0] bcd_exc = {4'h0, exc_code_q[3:0]}; // Codes 01..04
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      comm_fault_display_code <= 8'h00;
    end else if (send_exc) begin
      comm_fault_display_code <= bcd_exc;
    end else if (timeout_hit) begin
      comm_fault_display_code <= 8'h10; // Decimal ten
    end
  end

  // AXI4-Lite write path: address and data in either order
  wire wr_fire = aw_held && w_held && !s_axi_bvalid;
  assign s_axi_awready = !aw_held;
  assign s_axi_wready = !w_held;
  wire [2:0] w1c = (wr_fire && aw_addr_q == status_off) ? w_data_q[2:0] : 3'h0;
  wire [2:0] events = {timeout_hit, send_exc, req_done && req_comm_err};
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q <= 32'h0;
      s_axi_bvalid <= 1'b0;
      ctrl <= ctrl_reset;
      bus_idle_timeout_period <= timeout_reset;
      reply_delay_count <= delay_reset;
      slave_id <= 8'h01;
      mask <= 3'h0;
      status <= 3'h0;
    end else begin
      if (s_axi_awvalid && !aw_held) begin
        aw_held <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_held) begin
        w_held <= 1'b1;
        w_data_q <= s_axi_wdata;
      end
      if (wr_fire) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        case (aw_addr_q)
          ctrl_off: ctrl <= w_data_q;
          timeout_off: bus_idle_timeout_period <= w_data_q[15:0];
          delay_off: reply_delay_count <= (w_data_q[7:0] > delay_max) ? delay_max : w_data_q[7:0];
          mask_off: mask <= w_data_q[2:0];
          link_off: slave_id <= w_data_q[7:0];
          default: ;
        endcase
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      status <= (status & ~w1c) | events; // Set wins over clear
    end
  end
  assign s_axi_bresp = 2'b00;

  // Read path
  logic [31:0] rd_mux;
  always_comb begin
    case (s_axi_araddr)
      ctrl_off: rd_mux = ctrl;
      timeout_off: rd_mux = {16'h0, bus_idle_timeout_period};
      delay_off: rd_mux = {24'h0, reply_delay_count};
      status_off: rd_mux = {29'h0, status};
      mask_off: rd_mux = {29'h0, mask};
      fault_off: rd_mux = {22'h0, state, comm_fault_display_code};
      link_off: rd_mux = {23'h0, eff_ascii, eff_format, eff_baud};
      default: rd_mux = 32'h0;
    endcase
  end
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
    end else if (s_axi_arvalid && !s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_mux;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
  assign s_axi_rresp = 2'b00;
  assign irq = |(status & mask);

  drop_silent_a: assert property (@(posedge aclk) disable iff (!aresetn)
      state == st_idle && req_done && req_comm_err |=> state == st_idle)
    else $error("errored request was answered");
  code_func_a: assert property (@(posedge aclk) disable iff (!aresetn)
      accept && req_func_bad |=> exc_code_q == 8'h01)
    else $error("bad function not coded 01");
  code_addr_a: assert property (@(posedge aclk) disable iff (!aresetn)
      accept && !req_func_bad && req_addr_bad |=> exc_code_q == 8'h02)
    else $error("bad address not coded 02");
  code_value_a: assert property (@(posedge aclk) disable iff (!aresetn)
      accept && !req_func_bad && !req_addr_bad && req_value_bad |=> exc_code_q == 8'h03)
    else $error("bad value not coded 03");
  code_fail_a: assert property (@(posedge aclk) disable iff (!aresetn)
      accept && req_exec_fail && !req_func_bad && !req_addr_bad && !req_value_bad |=> exc_code_q == 8'h04)
    else $error("failed action not coded 04");
  display_exc_a: assert property (@(posedge aclk) disable iff (!aresetn)
      send_exc |=> comm_fault_display_code == exc_code_q && tx_valid)
    else $error("display or reply missing on exception");
  timeout_show_a: assert property (@(posedge aclk) disable iff (!aresetn)
      timeout_hit && !send_exc |=> comm_fault_display_code == 8'h10)
    else $error("timeout not shown as ten");
  delay_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
      accept && reply_delay_count == 8'h1 |=> state == st_wait [*2])
    else $error("reply sent before delay");
  keypad_fmt_a: assert property (@(posedge aclk) disable iff (!aresetn)
      keypad_port_select |-> eff_baud == keypad_baud_code && !eff_ascii)
    else $error("keypad format not forced");

  // Dropped frames and the reply wait
  drop_flag_a: assert property (@(posedge aclk) disable iff (!aresetn)
      req_done && req_comm_err |=> status[st_drop_bit])
    else $error("dropped frame not flagged");
  wait_quiet_a: assert property (@(posedge aclk) disable iff (!aresetn)
      state == st_wait && !delay_done |-> !tx_valid && !normal_reply_go)
    else $error("reply started inside delay");
  normal_pulse_a: assert property (@(posedge aclk) disable iff (!aresetn)
      normal_reply_go |=> !normal_reply_go)
    else $error("normal reply strobe longer than one cycle");

  // Register bus answers stand until taken
  bvalid_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response withdrawn early");
  rvalid_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data withdrawn or changed early");
endmodule : exc_reply_top

// file: dv/reply_sink.sv
// Partner model: the far end that takes reply bytes, with random stalls
module reply_sink (
  input wire logic aclk,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic tx_last,
  output logic tx_ready
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] got[$];
  logic got_last[$];
  logic hl;
  logic hs;
  logic [7:0] hd;
  initial tx_ready = 1'b0;
  // Look at the offer on the falling edge, where it has settled
  always @(negedge aclk) begin
    hs <= tx_valid && tx_ready;
    hd <= tx_data;
    hl <= tx_last;
  end
  // Take on the rising edge; ready is redrawn so the sender must cope with stalls
  always @(posedge aclk) begin
    if (hs === 1'b1) begin
      got.push_back(hd);
      got_last.push_back(hl);
    end
    tx_ready <= ($urandom % 3) != 0;
  end
endmodule : reply_sink

// file: dv/test_modbus_slave_exception_reply.sv
// Testbench: exception reply, display code, idle timeout, delay and forced link format
module test_modbus_slave_exception_reply;
  import exc_reply_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  typedef logic [7:0] bytes_t[$];
  localparam int du = 4;
  localparam int tu = 10;
  logic aclk = 1'b0;
  logic aresetn, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [7:0] awaddr, araddr, req_addr, req_func, tx_data, disp_code;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp;
  logic req_done, req_comm_err, req_func_bad, req_addr_bad, req_value_bad, req_exec_fail, bus_activity;
  logic tx_valid, tx_last, tx_ready, normal_reply_go, eff_ascii, irq;
  logic [3:0] eff_baud, eff_format;
  int errors = 0;
  int checks_done = 0;
  int cycles = 0;

  exc_reply_top #(.delay_unit(du), .timeout_unit(tu)) u_exc_reply_top (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .req_done(req_done), .req_comm_err(req_comm_err), .req_addr(req_addr), .req_func(req_func),
    .req_func_bad(req_func_bad), .req_addr_bad(req_addr_bad), .req_value_bad(req_value_bad),
    .req_exec_fail(req_exec_fail), .bus_activity(bus_activity),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last), .tx_ready(tx_ready),
    .normal_reply_go(normal_reply_go), .eff_baud(eff_baud), .eff_format(eff_format),
    .eff_ascii(eff_ascii), .comm_fault_display_code(disp_code), .irq(irq)
  );
  reply_sink u_reply_sink (
    .aclk(aclk), .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last), .tx_ready(tx_ready)
  );

  // Clock, and a watchdog that cuts a hang short
  always #25 aclk = ~aclk;
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : tally_and_finish

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // Bus master: handshakes judged on the falling edge, released after the rising one
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    logic aw, w, b;
    @(posedge aclk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wvalid <= 1'b1;
    bready <= 1'b1;
    b = 1'b0;
    while (!b) begin
      @(negedge aclk);
      aw = awvalid && awready;
      w = wvalid && wready;
      b = bvalid === 1'b1;
      if (b) check("bresp", bresp, 2'b00);
      @(posedge aclk);
      if (aw) awvalid <= 1'b0;
      if (w) wvalid <= 1'b0;
    end
    bready <= 1'b0;
  endtask : axi_wr

  task automatic rd_check(input string what, input logic [7:0] a, input logic [31:0] exp);
    logic ar, r;
    logic [31:0] d;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    r = 1'b0;
    while (!r) begin
      @(negedge aclk);
      ar = arvalid && arready;
      r = rvalid === 1'b1;
      d = rdata;
      if (r) check("rresp", rresp, 2'b00);
      @(posedge aclk);
      if (ar) arvalid <= 1'b0;
    end
    rready <= 1'b0;
    check(what, d, exp);
  endtask : rd_check

  function automatic logic [7:0] hexc(input logic [3:0] n);
    return (n < 4'ha) ? 8'h30 + n : 8'h37 + n;
  endfunction : hexc

  // Expected reply: CRC is low byte first, LRC is the negated byte sum
  function automatic bytes_t exp_frame(input logic [7:0] a, input logic [7:0] f, input logic [7:0] c,
                                       input logic asc);
    bytes_t q;
    logic [15:0] crc;
    logic [7:0] lrc;
    logic [7:0] b[3];
    b = '{a, f | 8'h80, c};
    crc = 16'hffff;
    lrc = 8'h00;
    foreach (b[i]) begin
      lrc = lrc + b[i];
      crc = crc ^ {8'h00, b[i]};
      for (int k = 0; k < 8; k++) crc = crc[0] ? (crc >> 1) ^ 16'ha001 : crc >> 1;
    end
    lrc = -lrc;
    if (asc) begin
      q = '{8'h3a};
      foreach (b[i]) q = {q, hexc(b[i][7:4]), hexc(b[i][3:0])};
      q = {q, hexc(lrc[7:4]), hexc(lrc[3:0]), 8'h0d, 8'h0a};
    end else begin
      q = '{b[0], b[1], b[2], crc[7:0], crc[15:8]};
    end
    return q;
  endfunction : exp_frame

  // One request: drive the verdict, wait out the delay, then compare the whole reply
  task automatic do_req(input logic [7:0] a, input logic [7:0] f, input logic [3:0] bad, input logic err,
                        input logic asc, input int dly);
    bytes_t q;
    int n;
    logic [7:0] c;
    logic go;
    c = bad[0] ? exc_func : bad[1] ? exc_addr : bad[2] ? exc_value : bad[3] ? exc_fail : 8'h00;
    q.delete();
    if (c != 8'h00 && !err) q = exp_frame(a, f, c, asc);
    u_reply_sink.got.delete();
    u_reply_sink.got_last.delete();
    @(posedge aclk);
    req_addr <= a;
    req_func <= f;
    {req_exec_fail, req_value_bad, req_addr_bad, req_func_bad} <= bad;
    req_comm_err <= err;
    req_done <= 1'b1;
    @(posedge aclk);
    req_done <= 1'b0;
    n = 0;
    go = 1'b0;
    repeat (dly * du + 12) begin
      @(negedge aclk);
      go = normal_reply_go === 1'b1;
      if (tx_valid === 1'b1 || go) break;
      n++;
    end
    if (q.size() > 0) check("reply delay", n >= dly * du && n < dly * du + 12, 1);
    else check("normal go", go, c == 8'h00 && !err);
    repeat (300) begin
      @(negedge aclk);
      if (u_reply_sink.got.size() >= q.size() && tx_valid !== 1'b1) break;
    end
    check("frame length", u_reply_sink.got.size(), q.size());
    foreach (q[i]) check("frame byte", u_reply_sink.got[i], q[i]);
    foreach (q[i]) check("frame end", u_reply_sink.got_last[i], i == q.size() - 1);
    if (q.size() > 0) check("display", disp_code, c);
    rd_check("status", status_off, err ? 1 : (c != 8'h00) ? 2 : 0);
    axi_wr(status_off, 32'h7);
  endtask : do_req

  initial begin
    logic asc;
    void'($urandom(32'hbb71));
    {aresetn, awvalid, wvalid, bready, arvalid, rready, req_done, req_comm_err} = '0;
    {req_func_bad, req_addr_bad, req_value_bad, req_exec_fail} = '0;
    {awaddr, araddr, req_addr, req_func, wdata} = '0;
    bus_activity = 1'b1;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    // Reset values, unmapped read, delay clamp
    rd_check("delay reset", delay_off, 1);
    rd_check("ctrl reset", ctrl_off, 0);
    rd_check("unmapped", 8'h1c, 0);
    axi_wr(delay_off, 32'hff);
    rd_check("delay clamp", delay_off, 200);
    $display("test registers done");
    // Keypad select overrides the programmed baud, format and framing
    axi_wr(ctrl_off, 32'h7a30);
    @(negedge aclk);
    check("kp link", {eff_baud, eff_format, eff_ascii}, {keypad_baud_code, keypad_fmt_code, 1'b0});
    axi_wr(ctrl_off, 32'h7a20);
    @(negedge aclk);
    check("own link", {eff_baud, eff_format, eff_ascii}, {4'ha, 4'h7, 1'b1});
    $display("test keypad done");
    // Every code alone, then random mixes for priority; framing and delay vary
    for (int i = 0; i < 12; i++) begin
      asc = i[0];
      axi_wr(ctrl_off, {26'h0, asc, 5'h0});
      axi_wr(delay_off, i % 4);
      do_req(8'($urandom), 8'($urandom), (i < 4) ? 4'(1 << i) : 4'($urandom_range(15, 1)), 1'b0, asc, i % 4);
    end
    do_req(8'($urandom), 8'h06, 4'($urandom_range(15, 1)), 1'b1, 1'b0, 3);
    do_req(8'h01, 8'h06, 4'h0, 1'b0, 1'b0, 3);
    // Keypad select must force RTU framing even with ASCII programmed
    axi_wr(ctrl_off, 32'h30);
    do_req(8'($urandom), 8'h06, 4'h2, 1'b0, 1'b0, 3);
    $display("test requests done");
    // Idle timeout, masking and clearing of the interrupt
    axi_wr(ctrl_off, 32'h0);
    axi_wr(timeout_off, 32'h2);
    bus_activity <= 1'b0;
    repeat (10) @(posedge aclk);
    rd_check("early idle", status_off, 0);
    repeat (20) @(posedge aclk);
    rd_check("idle flag", status_off, 4);
    check("idle display", disp_code, 8'h10);
    check("masked irq", irq, 1'b0);
    axi_wr(mask_off, 32'h4);
    @(negedge aclk);
    check("irq raised", irq, 1'b1);
    bus_activity <= 1'b1;
    axi_wr(status_off, 32'h7);
    @(negedge aclk);
    check("irq cleared", irq, 1'b0);
    axi_wr(ctrl_off, 32'h2);
    bus_activity <= 1'b0;
    repeat (30) @(posedge aclk);
    rd_check("treat 2 idle", status_off, 4);
    bus_activity <= 1'b1;
    axi_wr(status_off, 32'h7);
    axi_wr(ctrl_off, 32'h3);
    bus_activity <= 1'b0;
    repeat (40) @(posedge aclk);
    rd_check("treat 3 idle", status_off, 0);
    bus_activity <= 1'b1;
    $display("test timeout done");
    tally_and_finish();
  end
endmodule : test_modbus_slave_exception_reply
